// ---- hdl/ncs_pkg.sv ----
// Constants for the mixer oscillator and clock multiplier register slice.
// Assumes a 16-bit register word and an 8-bit register address.
package ncs_pkg;
	localparam int NCS_ADDR_W = 8;
	localparam int NCS_DATA_W = 16;
	localparam int NCS_ACC_W = 32;

	// Register offsets
	localparam logic [7:0] NCS_OFS_PHASE_SHIFT = 8'h12;
	localparam logic [7:0] NCS_OFS_RSVD_A = 8'h13;
	localparam logic [7:0] NCS_OFS_STEP_LOW = 8'h14;
	localparam logic [7:0] NCS_OFS_STEP_HIGH = 8'h15;
	localparam logic [7:0] NCS_OFS_RSVD_B = 8'h16;
	localparam logic [7:0] NCS_OFS_RSVD_C = 8'h17;
	localparam logic [7:0] NCS_OFS_MULT_CTRL = 8'h18;

	// Reset values
	localparam logic [15:0] NCS_RST_PHASE_SHIFT = 16'h0000;
	localparam logic [15:0] NCS_RST_STEP_LOW = 16'h0000;
	localparam logic [15:0] NCS_RST_STEP_HIGH = 16'h0000;
	localparam logic [15:0] NCS_RST_RSVD = 16'h0000;
	// Control bits 15:3 after reset: rsvd 001, clear 0, dsync 1, en 0, rsvd 00, pump 00, presc 001
	localparam logic [12:0] NCS_RST_MULT_CTRL = 13'h0501;

	// Control field positions
	localparam int NCS_BIT_LF_CLEAR = 12;
	localparam int NCS_BIT_DIV_SYNC = 11;
	localparam int NCS_BIT_MULT_EN = 10;
	localparam int NCS_PUMP_HI = 7;
	localparam int NCS_PUMP_LO = 6;
	localparam int NCS_PRESC_HI = 5;
	localparam int NCS_PRESC_LO = 3;
	localparam int NCS_LEVEL_HI = 2;
	localparam int NCS_CTRL_STORE_LO = 3;

	// Pump select codes
	localparam logic [1:0] NCS_PUMP_NONE = 2'h0;
	localparam logic [1:0] NCS_PUMP_SINGLE = 2'h1;
	localparam logic [1:0] NCS_PUMP_UNUSED = 2'h2;
	localparam logic [1:0] NCS_PUMP_DUAL = 2'h3;

	// Prescaler codes
	localparam logic [2:0] NCS_PRESC_CODE_8 = 3'h0;
	localparam logic [2:0] NCS_PRESC_CODE_1 = 3'h1;
	localparam logic [3:0] NCS_PRESC_RATIO_8 = 4'h8;
	localparam logic [3:0] NCS_PRESC_RATIO_1 = 4'h1;
endpackage

// ---- hdl/ncs_regs.sv ----
// Mixer oscillator and clock multiplier configuration registers with
// the phase accumulator and lookup address generation.
// Assumes a single-cycle register port on core_clk; sync pin and level
// indicator arrive asynchronously; auto-sync enable comes from core_clk logic.
//
// Functional notes
// RULE1: Lookup address is accumulator top plus shift
// RULE2: Phase shift write makes auto-sync when enabled
// RULE3: All mixer values load together on sync
// RULE4: Software writes step halves before phase shift
// RULE5: Step word is 32-bit two's complement
// RULE6: Accumulator adds step each cycle, wraps
// RULE7: Clear bit holds filter; falling edge restarts
// RULE8: Divider sync bit passes sync to dividers
// RULE9: Enable bit runs multiplier, else bypass
// RULE10: Two-bit pump select decode, reset none
// RULE11: Three-bit prescaler ratio decode, reset 001
// RULE12: Low three bits read filter level
// RULE13: Software tunes VCO for level 010-101
// RULE14: Top three bits reserved, reset 001
// RULE15: Reserved registers read zero, no effect
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module ncs_regs
	import ncs_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// Register port
	input wire logic [NCS_ADDR_W-1:0] reg_addr,
	input wire logic [NCS_DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [NCS_DATA_W-1:0] reg_rdata,
	// Mixer auto-sync enable from elsewhere in the map
	input wire logic mixer_autosync_config,
	// Asynchronous inputs
	input wire logic sync_in,
	input wire logic [2:0] lf_level_in,
	// Mixer outputs
	output logic [15:0] nco_lookup_addr,
	output logic nco_load_pulse,
	// Clock multiplier outputs
	output logic lf_clear,
	output logic mult_restart,
	output logic ndiv_sync,
	output logic mult_enable,
	output logic mult_bypass,
	output logic pump_single,
	output logic pump_dual,
	output logic [3:0] presc_ratio
);

	function automatic logic [3:0] presc_decode(input logic [2:0] code);
		if (code == NCS_PRESC_CODE_8)
			presc_decode = NCS_PRESC_RATIO_8;
		else if (code == NCS_PRESC_CODE_1)
			presc_decode = NCS_PRESC_RATIO_1;
		else
			presc_decode = {1'b0, code};
	endfunction

	function automatic logic wr_hit(input logic wr, input logic [NCS_ADDR_W-1:0] a, input logic [7:0] ofs);
		wr_hit = wr && (a == ofs);
	endfunction

	logic [15:0] phase_shift_reg;
	logic [15:0] step_low_reg;
	logic [15:0] step_high_reg;
	logic [12:0] ctrl_reg;
	logic [15:0] phase_active_reg;
	logic [31:0] step_active_reg;
	logic [31:0] acc_reg;
	logic sync_pend_reg;
	logic sync_s1_reg;
	logic sync_s2_reg;
	logic sync_s3_reg;
	logic [2:0] lvl_s1_reg;
	logic [2:0] lvl_s2_reg;
	logic ctrl_clear_prev_reg;
	logic [15:0] rdata_next;

	// Software-visible registers
	always_ff @(posedge core_clk) begin
		if (srst) begin
			phase_shift_reg <= NCS_RST_PHASE_SHIFT;
			step_low_reg <= NCS_RST_STEP_LOW;
			step_high_reg <= NCS_RST_STEP_HIGH;
			ctrl_reg <= NCS_RST_MULT_CTRL; // RULE14
		end else begin
			if (wr_hit(reg_wr, reg_addr, NCS_OFS_PHASE_SHIFT))
				phase_shift_reg <= reg_wdata;
			if (wr_hit(reg_wr, reg_addr, NCS_OFS_STEP_LOW))
				step_low_reg <= reg_wdata;
			if (wr_hit(reg_wr, reg_addr, NCS_OFS_STEP_HIGH))
				step_high_reg <= reg_wdata;
			// Level bits are not stored, so writes to them vanish
			if (wr_hit(reg_wr, reg_addr, NCS_OFS_MULT_CTRL))
				ctrl_reg <= reg_wdata[15:NCS_CTRL_STORE_LO]; // RULE12 RULE14
		end
	end

	// Auto-sync request, applied one edge after the phase shift write
	always_ff @(posedge core_clk) begin
		if (srst)
			sync_pend_reg <= 1'b0;
		else
			sync_pend_reg <= wr_hit(reg_wr, reg_addr, NCS_OFS_PHASE_SHIFT) && mixer_autosync_config; // RULE2
	end

	// Active mixer settings change only together
	always_ff @(posedge core_clk) begin
		if (srst) begin
			phase_active_reg <= NCS_RST_PHASE_SHIFT;
			step_active_reg <= {NCS_RST_STEP_HIGH, NCS_RST_STEP_LOW};
		end else if (sync_pend_reg) begin
			phase_active_reg <= phase_shift_reg; // RULE3
			step_active_reg <= {step_high_reg, step_low_reg}; // RULE3 RULE5
		end
	end

	// Unsigned add of a two's complement step gives the signed wrap for free
	always_ff @(posedge core_clk) begin
		if (srst)
			acc_reg <= 32'h0000_0000;
		else
			acc_reg <= acc_reg + step_active_reg; // RULE6 RULE5
	end

	always_ff @(posedge core_clk) begin
		if (srst)
			nco_lookup_addr <= 16'h0000;
		else
			nco_lookup_addr <= acc_reg[31:16] + phase_active_reg; // RULE1
	end

	always_ff @(posedge core_clk) begin
		if (srst)
			nco_load_pulse <= 1'b0;
		else
			nco_load_pulse <= sync_pend_reg;
	end

	// Pin synchronisers; s3 is only the edge-detect history
	always_ff @(posedge core_clk) begin
		if (srst) begin
			sync_s1_reg <= 1'b0;
			sync_s2_reg <= 1'b0;
			sync_s3_reg <= 1'b0;
			lvl_s1_reg <= 3'h0;
			lvl_s2_reg <= 3'h0;
		end else begin
			sync_s1_reg <= sync_in;
			sync_s2_reg <= sync_s1_reg;
			sync_s3_reg <= sync_s2_reg;
			// Multi-bit level may tear for a cycle; it is a slow indicator
			lvl_s1_reg <= lf_level_in;
			lvl_s2_reg <= lvl_s1_reg;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst)
			ndiv_sync <= 1'b0;
		else
			ndiv_sync <= ctrl_reg[NCS_BIT_DIV_SYNC - NCS_CTRL_STORE_LO] && sync_s2_reg && !sync_s3_reg; // RULE8
	end

	// Loop filter clear level and restart on its falling edge
	always_ff @(posedge core_clk) begin
		if (srst) begin
			ctrl_clear_prev_reg <= 1'b0;
			lf_clear <= 1'b0;
			mult_restart <= 1'b0;
		end else begin
			ctrl_clear_prev_reg <= ctrl_reg[NCS_BIT_LF_CLEAR - NCS_CTRL_STORE_LO];
			lf_clear <= ctrl_reg[NCS_BIT_LF_CLEAR - NCS_CTRL_STORE_LO]; // RULE7
			mult_restart <= ctrl_clear_prev_reg && !ctrl_reg[NCS_BIT_LF_CLEAR - NCS_CTRL_STORE_LO]; // RULE7
		end
	end

	// Multiplier mode decode
	always_ff @(posedge core_clk) begin
		if (srst) begin
			mult_enable <= 1'b0;
			mult_bypass <= 1'b1;
			pump_single <= 1'b0;
			pump_dual <= 1'b0;
			presc_ratio <= NCS_PRESC_RATIO_1;
		end else begin
			mult_enable <= ctrl_reg[NCS_BIT_MULT_EN - NCS_CTRL_STORE_LO]; // RULE9
			mult_bypass <= !ctrl_reg[NCS_BIT_MULT_EN - NCS_CTRL_STORE_LO]; // RULE9
			// Unused code drives no pump
			pump_single <= ctrl_reg[NCS_PUMP_HI - NCS_CTRL_STORE_LO -: 2] == NCS_PUMP_SINGLE; // RULE10
			pump_dual <= ctrl_reg[NCS_PUMP_HI - NCS_CTRL_STORE_LO -: 2] == NCS_PUMP_DUAL; // RULE10
			presc_ratio <= presc_decode(ctrl_reg[NCS_PRESC_HI - NCS_CTRL_STORE_LO -: 3]); // RULE11
		end
	end

	// Read mux; reserved and unmapped words read zero
	always_comb begin
		rdata_next = 16'h0000;
		unique case (reg_addr)
			NCS_OFS_PHASE_SHIFT: rdata_next = phase_shift_reg;
			NCS_OFS_STEP_LOW: rdata_next = step_low_reg;
			NCS_OFS_STEP_HIGH: rdata_next = step_high_reg;
			NCS_OFS_MULT_CTRL: rdata_next = {ctrl_reg, lvl_s2_reg}; // RULE12
			NCS_OFS_RSVD_A, NCS_OFS_RSVD_B, NCS_OFS_RSVD_C: rdata_next = NCS_RST_RSVD; // RULE15
			default: rdata_next = 16'h0000;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (srst)
			reg_rdata <= 16'h0000;
		else if (reg_rd)
			reg_rdata <= rdata_next;
		else
			reg_rdata <= 16'h0000;
	end

	// Checks
	sequence s_shift_write;
		reg_wr && reg_addr == NCS_OFS_PHASE_SHIFT && mixer_autosync_config;
	endsequence

	// Compare with the written value, since a back-to-back write may already have replaced it
	sequence s_load_done;
		nco_load_pulse && phase_active_reg == $past(phase_shift_reg);
	endsequence

	a_autosync_load_pulse: assert property (@(posedge core_clk) disable iff (srst) // RULE2
		s_shift_write |-> ##1 sync_pend_reg ##1 s_load_done)
		else $error("Phase shift write did not load mixer");

	a_step_held_nosync: assert property (@(posedge core_clk) disable iff (srst) // RULE3
		!sync_pend_reg |=> $stable(step_active_reg) && $stable(phase_active_reg))
		else $error("Active mixer values moved without sync");

	a_no_sync_off: assert property (@(posedge core_clk) disable iff (srst) // RULE2
		reg_wr && reg_addr == NCS_OFS_PHASE_SHIFT && !mixer_autosync_config |=> !sync_pend_reg)
		else $error("Auto-sync raised while disabled");

	a_acc_step: assert property (@(posedge core_clk) disable iff (srst) // RULE6
		!$past(srst) |-> acc_reg == 32'($past(acc_reg) + $past(step_active_reg)))
		else $error("Accumulator did not add step");

	a_lookup_sum: assert property (@(posedge core_clk) disable iff (srst) // RULE1
		##1 nco_lookup_addr == 16'($past(acc_reg[31:16]) + $past(phase_active_reg)))
		else $error("Lookup address wrong");

	a_restart_edge: assert property (@(posedge core_clk) disable iff (srst) // RULE7
		$fell(ctrl_reg[NCS_BIT_LF_CLEAR - NCS_CTRL_STORE_LO]) |=> mult_restart ##1 !mult_restart)
		else $error("Restart pulse missing after clear release");

	a_bypass_excl: assert property (@(posedge core_clk) disable iff (srst) // RULE9
		mult_enable != mult_bypass)
		else $error("Enable and bypass agree");

	a_pump_decode: assert property (@(posedge core_clk) disable iff (srst) // RULE10
		ctrl_reg[NCS_PUMP_HI - NCS_CTRL_STORE_LO -: 2] == NCS_PUMP_UNUSED [*2] |-> !pump_single && !pump_dual)
		else $error("Unused pump code drove a pump");

	a_presc_eight: assert property (@(posedge core_clk) disable iff (srst) // RULE11
		ctrl_reg[NCS_PRESC_HI - NCS_CTRL_STORE_LO -: 3] == NCS_PRESC_CODE_8 |=> presc_ratio == NCS_PRESC_RATIO_8)
		else $error("Prescaler code 000 not ratio 8");

	a_dsync_gate: assert property (@(posedge core_clk) disable iff (srst) // RULE8
		ndiv_sync |-> $past(ctrl_reg[NCS_BIT_DIV_SYNC - NCS_CTRL_STORE_LO]) && $past(sync_s2_reg))
		else $error("Divider sync without enable");

	a_rsvd_zero: assert property (@(posedge core_clk) disable iff (srst) // RULE15
		reg_rd && (reg_addr == NCS_OFS_RSVD_A || reg_addr == NCS_OFS_RSVD_C) |=> reg_rdata == 16'h0000)
		else $error("Reserved register read nonzero");

	a_level_read: assert property (@(posedge core_clk) disable iff (srst) // RULE12
		reg_rd && reg_addr == NCS_OFS_MULT_CTRL |=> reg_rdata[NCS_LEVEL_HI:0] == $past(lvl_s2_reg))
		else $error("Level bits not from indicator");

endmodule // ncs_regs
`default_nettype wire

// ---- testbench/ncs_regs_tb.sv ----
// Self-checking bench for the mixer and clock multiplier register slice.
// Assumes ncs_pkg is compiled first; the bench drives every port itself.
`timescale 1ns/1ps
`default_nettype none
module ncs_regs_tb import ncs_pkg::*;;
	typedef struct {logic [7:0] a; logic [15:0] w; logic [15:0] r;} ncs_row_s;
	logic core_clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, autosync = 0, sync_in = 0;
	logic [7:0] reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata, nco_addr, a1, a2, rv;
	logic [2:0] lvl = 3'h5;
	logic load_p, lf_clear, restart, ndiv_sync, m_en, m_byp, p_single, p_dual;
	logic [3:0] presc;
	int fails = 0, num_checks = 0, tick = 0, n_load = 0, n_rst = 0, n_sync = 0, c0;
	ncs_row_s rows [8] = '{'{8'h12, 16'ha5a5, 16'ha5a5}, '{8'h13, 16'hffff, 16'h0000},
		'{8'h14, 16'h1234, 16'h1234}, '{8'h15, 16'h8765, 16'h8765}, '{8'h16, 16'hffff, 16'h0000},
		'{8'h17, 16'hffff, 16'h0000}, '{8'h18, 16'hffff, 16'hfffd}, '{8'h40, 16'hffff, 16'h0000}};

	ncs_regs DUT (.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mixer_autosync_config(autosync),
		.sync_in(sync_in), .lf_level_in(lvl), .nco_lookup_addr(nco_addr), .nco_load_pulse(load_p),
		.lf_clear(lf_clear), .mult_restart(restart), .ndiv_sync(ndiv_sync), .mult_enable(m_en),
		.mult_bypass(m_byp), .pump_single(p_single), .pump_dual(p_dual), .presc_ratio(presc));

	initial begin
		forever #20 core_clk = ~core_clk;
	end

	// Pulse counters; the limit is several times the expected run length
	always @(posedge core_clk) begin
		tick++;
		n_load += (load_p === 1'b1);
		n_rst += (restart === 1'b1);
		n_sync += (ndiv_sync === 1'b1);
		if (tick == 3000) begin
			fails++;
			close_out();
		end
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		rv = reg_rdata;
	endtask

	task automatic chk_reset();
		for (int i = 0; i < 6; i++) begin
			rd(8'h12 + 8'(i));
			chk(rv, 16'h0000);
		end
		rd(8'h18);
		chk(rv, 16'h2808 | 16'(lvl));
		chk(16'(rv[2:0] >= 3'h2 && rv[2:0] <= 3'h5), 16'h0001);
		chk({11'h000, m_byp, presc}, 16'h0011);
	endtask

	task automatic mix(input logic [31:0] step, input logic [15:0] ph, input logic en);
		wr(8'h14, step[15:0]);
		wr(8'h15, step[31:16]);
		autosync <= en;
		wr(8'h12, ph);
		cyc(5);
		autosync <= 1'b0;
		a1 = nco_addr;
		cyc(1);
		a2 = nco_addr;
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial begin
		cyc(20);
		srst <= 1'b0;
		chk_reset();
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].w);
			rd(rows[i].a);
			chk(rv, rows[i].r);
		end
		chk(nco_addr, 16'h0000);
		chk(16'(n_load), 16'h0000);
		mix(32'h0000_0000, 16'h0100, 1'b1);
		chk(a2, 16'h0100);
		chk(16'(n_load), 16'h0001);
		mix(32'h0001_0000, 16'h0100, 1'b1);
		chk(a2 - a1, 16'h0001);
		mix(32'hffff_0000, 16'h0100, 1'b1);
		chk(a2 - a1, 16'hffff);
		mix(32'h0000_0000, 16'h0100, 1'b1);
		rv = a2;
		mix(32'h0000_0000, 16'h0110, 1'b1);
		chk(a2 - rv, 16'h0010);
		c0 = n_load;
		mix(32'h0001_0000, 16'h0200, 1'b0);
		chk(a2 - a1, 16'h0000);
		chk(16'(n_load - c0), 16'h0000);
		for (int i = 0; i < 8; i++) begin
			wr(8'h18, {3'b001, 2'b01, i[0], 2'b00, i[1:0], i[2:0], 3'b000});
			cyc(3);
			chk({8'h00, m_en, m_byp, p_single, p_dual, presc}, {8'h00, i[0], ~i[0], i[1:0] == 2'd1,
				i[1:0] == 2'd3, i == 0 ? 4'h8 : i == 1 ? 4'h1 : 4'(i)});
		end
		wr(8'h18, 16'h3800);
		cyc(3);
		chk({15'h0000, lf_clear}, 16'h0001);
		c0 = n_rst;
		wr(8'h18, 16'h2800);
		cyc(4);
		chk({15'h0000, lf_clear}, 16'h0000);
		chk(16'(n_rst - c0), 16'h0001);
		for (int i = 0; i < 2; i++) begin
			c0 = n_sync;
			sync_in <= 1'b1;
			cyc(6);
			sync_in <= 1'b0;
			cyc(3);
			chk(16'(n_sync - c0), i == 0 ? 16'h0001 : 16'h0000);
			wr(8'h18, 16'h2000);
		end
		// Mid-run reset must restore every register word, the bypass and the prescaler ratio
		lvl <= 3'h2;
		srst <= 1'b1;
		cyc(2);
		srst <= 1'b0;
		chk_reset();
		close_out();
	end
endmodule // ncs_regs_tb
`default_nettype wire
